// ### hw/rect_alpha_fade_blend.sv
// Purpose: rectangle alpha blending with fade for a graphics layer or the synthesizer
// Assumes: pixel positions arrive relative to the layer's display area start
// Notes:   one clock; registers over APB, always ready, no wait states
//
// Behaviour
// - blend enable separate from parameter registers
// - parameters hold until reset or rewrite
// - rectangle start is offset from area start
// - size in lines and cycles; outside unblended
// - rectangle never follows area changes; software reprograms
// - add signed step every interval+1 vsync rises
// - interval 0..255, resets to zero
// - start alpha 8 bits, resets to 255
// - optional multiply by pixel's own alpha
// - swap bit picks synthesizer lower plane
// - swap only matters with two scaled images
// - synthesizer may be the blend target
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "rect_blend_consts.svh"
`default_nettype none

module rect_alpha_fade_blend (
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_n_i,
  // apb slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [7:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // timing
  input  wire logic                  vsync_i,
  input  wire logic                  pix_valid_i,
  input  wire rect_blend_pkg::coord_t pos_x_i,
  input  wire rect_blend_pkg::coord_t pos_y_i,
  input  wire logic                  dual_scaler_i,
  // graphics layer target pixels
  input  wire rect_blend_pkg::rgb_t  layer_rgb_i,
  input  wire rect_blend_pkg::alpha_t layer_alpha_i,
  input  wire rect_blend_pkg::rgb_t  under_rgb_i,
  // synthesizer target pixels
  input  wire rect_blend_pkg::rgb_t  gfx0_rgb_i,
  input  wire rect_blend_pkg::alpha_t gfx0_alpha_i,
  input  wire rect_blend_pkg::rgb_t  gfx1_rgb_i,
  input  wire rect_blend_pkg::alpha_t gfx1_alpha_i,
  // blended output
  output rect_blend_pkg::rgb_t       out_rgb_o,
  output logic                       out_valid_o,
  output rect_blend_pkg::alpha_t     fade_alpha_o
);

  // configuration registers
  logic                    rect_blend_enable;
  rect_blend_pkg::coord_t  rect_top_offset;
  rect_blend_pkg::coord_t  rect_height_lines;
  rect_blend_pkg::coord_t  rect_left_offset;
  rect_blend_pkg::coord_t  rect_width_cycles;
  rect_blend_pkg::step_t   fade_step;
  rect_blend_pkg::alpha_t  fade_interval;
  rect_blend_pkg::alpha_t  start_alpha;
  logic                    multiply_pixel_alpha;
  logic                    lower_plane_swap;
  logic                    synth_target;
  logic                    next_rect_blend_enable;
  rect_blend_pkg::coord_t  next_rect_top_offset;
  rect_blend_pkg::coord_t  next_rect_height_lines;
  rect_blend_pkg::coord_t  next_rect_left_offset;
  rect_blend_pkg::coord_t  next_rect_width_cycles;
  rect_blend_pkg::step_t   next_fade_step;
  rect_blend_pkg::alpha_t  next_fade_interval;
  rect_blend_pkg::alpha_t  next_start_alpha;
  logic                    next_multiply_pixel_alpha;
  logic                    next_lower_plane_swap;
  logic                    next_synth_target;

  // fade state
  rect_blend_pkg::alpha_t  cur_alpha;
  rect_blend_pkg::alpha_t  vs_count;
  logic                    vsync_d;
  rect_blend_pkg::alpha_t  next_cur_alpha;
  rect_blend_pkg::alpha_t  next_vs_count;

  // output state
  rect_blend_pkg::rgb_t    next_out_rgb;
  logic                    in_rect;
  logic                    in_rect_q;

  logic                    wr_en;
  logic                    acc;
  logic                    mapped;
  logic                    start_written;
  rect_blend_pkg::step_t   wr_step;

  assign acc      = psel_i & penable_i;
  assign wr_en    = acc & pwrite_i;
  assign pready_o = 1'b1;
  assign mapped   = paddr_i inside {`RB_OFF_CTRL, `RB_OFF_RECT_V, `RB_OFF_RECT_H, `RB_OFF_FADE,
                                    `RB_OFF_ALPHA, `RB_OFF_SELECT, `RB_OFF_STATUS};

  // status is read-only, so writes to it are refused too
  assign pslverr_o = acc & (~mapped | (pwrite_i & (paddr_i == `RB_OFF_STATUS)));

  // -256 is outside the legal step span; pull it to the nearest legal value
  assign wr_step = (pwdata_i[`RB_STEP_LO+8:`RB_STEP_LO] == 9'h100) ? `RB_STEP_MIN
                 : pwdata_i[`RB_STEP_LO+8:`RB_STEP_LO];

  always_comb
  begin
    next_rect_blend_enable    = rect_blend_enable;
    next_rect_top_offset      = rect_top_offset;
    next_rect_height_lines    = rect_height_lines;
    next_rect_left_offset     = rect_left_offset;
    next_rect_width_cycles    = rect_width_cycles;
    next_fade_step            = fade_step;
    next_fade_interval        = fade_interval;
    next_start_alpha          = start_alpha;
    next_multiply_pixel_alpha = multiply_pixel_alpha;
    next_lower_plane_swap     = lower_plane_swap;
    next_synth_target         = synth_target;
    start_written             = 1'b0;
    if (wr_en)
    begin
      // on/off and parameters sit in different words
      unique case (paddr_i)
        `RB_OFF_CTRL:
          next_rect_blend_enable = pwdata_i[`RB_CTRL_EN_BIT];
        `RB_OFF_RECT_V:
        begin
          next_rect_top_offset   = pwdata_i[`RB_POS_LO+10:`RB_POS_LO];
          next_rect_height_lines = pwdata_i[`RB_SIZE_LO+10:`RB_SIZE_LO];
        end
        `RB_OFF_RECT_H:
        begin
          next_rect_left_offset  = pwdata_i[`RB_POS_LO+10:`RB_POS_LO];
          next_rect_width_cycles = pwdata_i[`RB_SIZE_LO+10:`RB_SIZE_LO];
        end
        `RB_OFF_FADE:
        begin
          next_fade_step     = wr_step;
          next_fade_interval = pwdata_i[`RB_INTERVAL_LO+7:`RB_INTERVAL_LO];
        end
        `RB_OFF_ALPHA:
        begin
          next_start_alpha          = pwdata_i[`RB_START_LO+7:`RB_START_LO];
          next_multiply_pixel_alpha = pwdata_i[`RB_MUL_BIT];
          start_written             = 1'b1;
        end
        `RB_OFF_SELECT:
        begin
          next_lower_plane_swap = pwdata_i[`RB_SWAP_BIT];
          next_synth_target     = pwdata_i[`RB_SYNTH_BIT];
        end
        default: next_rect_blend_enable = rect_blend_enable;
      endcase
    end
  end

  // values change only by reset or by a write
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      rect_blend_enable    <= 1'b0;
      rect_top_offset      <= '0;
      rect_height_lines    <= '0;
      rect_left_offset     <= '0;
      rect_width_cycles    <= '0;
      fade_step            <= `RB_RST_STEP;
      fade_interval        <= `RB_RST_INTERVAL;
      start_alpha          <= `RB_RST_START_ALPHA;
      multiply_pixel_alpha <= 1'b0;
      lower_plane_swap     <= 1'b0;
      synth_target         <= 1'b0;
    end
    else
    begin
      rect_blend_enable    <= next_rect_blend_enable;
      rect_top_offset      <= next_rect_top_offset;
      rect_height_lines    <= next_rect_height_lines;
      rect_left_offset     <= next_rect_left_offset;
      rect_width_cycles    <= next_rect_width_cycles;
      fade_step            <= next_fade_step;
      fade_interval        <= next_fade_interval;
      start_alpha          <= next_start_alpha;
      multiply_pixel_alpha <= next_multiply_pixel_alpha;
      lower_plane_swap     <= next_lower_plane_swap;
      synth_target         <= next_synth_target;
    end
  end

  always_comb
  begin
    prdata_o = 32'h0000_0000;
    if (acc & ~pwrite_i)
    begin
      unique case (paddr_i)
        `RB_OFF_CTRL:   prdata_o[`RB_CTRL_EN_BIT] = rect_blend_enable;
        `RB_OFF_RECT_V: prdata_o = {5'h00, rect_height_lines, 5'h00, rect_top_offset};
        `RB_OFF_RECT_H: prdata_o = {5'h00, rect_width_cycles, 5'h00, rect_left_offset};
        `RB_OFF_FADE:   prdata_o = {8'h00, fade_interval, 7'h00, fade_step};
        `RB_OFF_ALPHA:  prdata_o = {23'h000000, multiply_pixel_alpha, start_alpha};
        `RB_OFF_SELECT: prdata_o = {30'h00000000, synth_target, lower_plane_swap};
        `RB_OFF_STATUS: prdata_o = {23'h000000, in_rect_q, cur_alpha};
        default:        prdata_o = 32'h0000_0000;
      endcase
    end
  end

  // fade engine
  logic              vs_rise;
  logic signed [9:0] alpha_sum;

  assign vs_rise   = vsync_i & ~vsync_d;
  assign alpha_sum = $signed({2'b00, cur_alpha}) + $signed({fade_step[8], fade_step});

  always_comb
  begin
    next_cur_alpha = cur_alpha;
    next_vs_count  = vs_count;
    if (!rect_blend_enable || start_written)
    begin
      // fading restarts from the start value whenever it is rewritten or blending is off
      next_cur_alpha = start_written ? next_start_alpha : start_alpha;
      next_vs_count  = 8'h00;
    end
    else if (vs_rise)
    begin
      if (vs_count >= fade_interval)
      begin
        next_vs_count = 8'h00;
        if (alpha_sum < 0)
          next_cur_alpha = 8'h00;
        else if (alpha_sum > $signed({2'b00, `RB_ALPHA_MAX}))
          next_cur_alpha = `RB_ALPHA_MAX;
        else
          next_cur_alpha = alpha_sum[7:0];
      end
      else
        next_vs_count = vs_count + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      cur_alpha <= `RB_RST_START_ALPHA;
      vs_count  <= 8'h00;
      vsync_d   <= 1'b0;
    end
    else
    begin
      cur_alpha <= next_cur_alpha;
      vs_count  <= next_vs_count;
      vsync_d   <= vsync_i;
    end
  end

  // pixel path: positions are area-relative, so the window is held in
  // area coordinates and does not track area moves
  logic [11:0]             y_end;
  logic [11:0]             x_end;
  rect_blend_pkg::rgb_t    top_rgb;
  rect_blend_pkg::alpha_t  top_alpha;
  rect_blend_pkg::rgb_t    bot_rgb;
  rect_blend_pkg::alpha_t  eff_alpha;
  logic [15:0]             amul;
  logic [15:0]             amul_r;
  logic                    swapped;

  assign y_end   = {1'b0, rect_top_offset} + {1'b0, rect_height_lines};
  assign x_end   = {1'b0, rect_left_offset} + {1'b0, rect_width_cycles};
  assign in_rect = ({1'b0, pos_y_i} >= {1'b0, rect_top_offset}) && ({1'b0, pos_y_i} < y_end)
                && ({1'b0, pos_x_i} >= {1'b0, rect_left_offset}) && ({1'b0, pos_x_i} < x_end);
  // the swap is ignored unless both scalers feed two images
  assign swapped = synth_target & dual_scaler_i & lower_plane_swap;
  // synthesizer: graphics 1 is current over graphics 0 unless swapped
  assign top_rgb   = synth_target ? (swapped ? gfx0_rgb_i : gfx1_rgb_i) : layer_rgb_i;
  assign top_alpha = synth_target ? (swapped ? gfx0_alpha_i : gfx1_alpha_i) : layer_alpha_i;
  assign bot_rgb   = synth_target ? (swapped ? gfx1_rgb_i : gfx0_rgb_i) : under_rgb_i;

  // divide by 255 with rounding, kept cheap by shift-and-add
  assign amul   = cur_alpha * top_alpha;
  assign amul_r = amul + 16'h0080;
  assign eff_alpha = multiply_pixel_alpha
                   ? 8'((amul_r + {8'h00, amul_r[15:8]}) >> 8)
                   : cur_alpha;

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++)
    begin : g_chan
      logic [16:0] mix;
      logic [16:0] mix_r;
      assign mix   = 17'(top_rgb[ch*8 +: 8] * eff_alpha)
                   + 17'(bot_rgb[ch*8 +: 8] * (8'hFF - eff_alpha));
      assign mix_r = mix + 17'h00080;
      always_comb
      begin
        if (rect_blend_enable && in_rect)
          next_out_rgb[ch*8 +: 8] = 8'((mix_r + {8'h00, mix_r[16:8]}) >> 8);
        else
          next_out_rgb[ch*8 +: 8] = top_rgb[ch*8 +: 8];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      out_rgb_o   <= 24'h000000;
      out_valid_o <= 1'b0;
      in_rect_q   <= 1'b0;
    end
    else
    begin
      out_rgb_o   <= next_out_rgb;
      out_valid_o <= pix_valid_i;
      in_rect_q   <= pix_valid_i & in_rect;
    end
  end

  assign fade_alpha_o = cur_alpha;

endmodule : rect_alpha_fade_blend

`default_nettype wire

// ### hw/rect_blend_consts.svh
// Purpose: offsets, field positions, reset values of the rectangle blend stage
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   definitions only
`ifndef RECT_BLEND_CONSTS_SVH
`define RECT_BLEND_CONSTS_SVH

`define RB_ADDR_W          8
`define RB_OFF_CTRL        8'h00
`define RB_OFF_RECT_V      8'h04
`define RB_OFF_RECT_H      8'h08
`define RB_OFF_FADE        8'h0C
`define RB_OFF_ALPHA       8'h10
`define RB_OFF_SELECT      8'h14
`define RB_OFF_STATUS      8'h18

`define RB_CTRL_EN_BIT     0
`define RB_POS_LO          0
`define RB_SIZE_LO         16
`define RB_STEP_LO         0
`define RB_INTERVAL_LO     16
`define RB_START_LO        0
`define RB_MUL_BIT         8
`define RB_SWAP_BIT        0
`define RB_SYNTH_BIT       1
`define RB_STAT_INRECT_BIT 8

`define RB_RST_START_ALPHA 8'hFF
`define RB_RST_INTERVAL    8'h00
`define RB_RST_STEP        9'h000
`define RB_STEP_MAX        9'h0FF
`define RB_STEP_MIN        9'h101
`define RB_ALPHA_MAX       8'hFF

`endif

// ### hw/rect_blend_pkg.sv
// Purpose: shared types of the rectangle blend stage
// Assumes: positions fit 11 bits, 8-bit colour and alpha
// Notes:   constants live in rect_blend_consts.svh
package rect_blend_pkg;
  typedef logic        [10:0] coord_t;
  typedef logic        [7:0]  alpha_t;
  typedef logic signed [8:0]  step_t;
  typedef logic        [23:0] rgb_t;
endpackage : rect_blend_pkg

// ### sim/rect_blend_assertions.sv
// Purpose: port checks of the rectangle blend stage
// Assumes: zero-wait APB; enable, select and fade fields shadowed from writes
// Notes:   bound to the design at the foot
`timescale 1ns/1ps
`default_nettype none
module rect_blend_checker (
  // clock, reset, bus
  input wire logic                   sys_clk_i,
  input wire logic                   reset_n_i,
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pwrite_i,
  input wire logic [7:0]             paddr_i,
  input wire logic [31:0]            pwdata_i,
  input wire logic [31:0]            prdata_o,
  input wire logic                   pslverr_o,
  // pixels
  input wire logic                   vsync_i,
  input wire logic                   pix_valid_i,
  input wire logic                   dual_scaler_i,
  input wire rect_blend_pkg::rgb_t   layer_rgb_i,
  input wire rect_blend_pkg::rgb_t   gfx0_rgb_i,
  input wire rect_blend_pkg::rgb_t   gfx1_rgb_i,
  input wire rect_blend_pkg::rgb_t   out_rgb_o,
  input wire logic                   out_valid_o,
  input wire rect_blend_pkg::alpha_t fade_alpha_o
);
  logic                wr;
  logic                en_q, sw_q, sy_q, next_en, next_sw, next_sy;
  logic signed [8:0]   st_q, next_st;
  logic [7:0]          iv_q, next_iv;
  logic signed [10:0]  sum;
  logic [7:0]          exp_a;
  rect_blend_pkg::rgb_t top;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  assign wr = psel_i && penable_i && pwrite_i;
  always_comb
  begin
    {next_en, next_sw, next_sy, next_st, next_iv} = {en_q, sw_q, sy_q, st_q, iv_q};
    if (wr && paddr_i == 8'h00)
      next_en = pwdata_i[0];
    if (wr && paddr_i == 8'h0C)
      {next_iv, next_st} = {pwdata_i[23:16], pwdata_i[8:0]};
    if (wr && paddr_i == 8'h14)
      {next_sy, next_sw} = pwdata_i[1:0];
    sum = $signed({3'b000, fade_alpha_o}) + 11'(st_q);
    exp_a = sum < 0 ? 8'h00 : (sum > 255 ? 8'hFF : sum[7:0]);
    top = sy_q ? ((sw_q && dual_scaler_i) ? gfx0_rgb_i : gfx1_rgb_i) : layer_rgb_i;
  end
  always_ff @(posedge sys_clk_i)
    if (!reset_n_i)
      {en_q, sw_q, sy_q, st_q, iv_q} <= '0;
    else
      {en_q, sw_q, sy_q, st_q, iv_q} <= {next_en, next_sw, next_sy, next_st, next_iv};
  // no read data leaks outside a read access
  a_idle_quiet: assert property (!(psel_i && penable_i && !pwrite_i) |-> prdata_o == 32'h0)
    else $error("read data outside read access");
  a_bus_error: assert property (psel_i && penable_i && (paddr_i > 8'h18 ||
    (pwrite_i && paddr_i == 8'h18)) |-> pslverr_o)
    else $error("bad access not refused");
  a_ctrl_readback: assert property (psel_i && penable_i && !pwrite_i && paddr_i == 8'h00
    |-> prdata_o == {31'h0, en_q})
    else $error("enable readback wrong");
  a_valid_delay: assert property (reset_n_i |=> out_valid_o == $past(pix_valid_i))
    else $error("valid not one cycle late");
  a_reset_opaque: assert property (disable iff (1'b0) !reset_n_i
    |=> fade_alpha_o == 8'hFF && !out_valid_o && out_rgb_o == 24'h0)
    else $error("reset outputs wrong");
  a_alpha_hold: assert property (!wr && !$past(wr) && !(vsync_i && !$past(vsync_i))
    |=> $stable(fade_alpha_o))
    else $error("alpha moved without cause");
  a_step_clamp: assert property (en_q && iv_q == 8'h00 && vsync_i && !$past(vsync_i) && !wr
    && !$past(wr) |=> fade_alpha_o == $past(exp_a))
    else $error("fade step wrong");
  a_pass_off: assert property (reset_n_i && !en_q |=> out_rgb_o == $past(top))
    else $error("disabled pixel not passed");
endmodule : rect_blend_checker
bind rect_alpha_fade_blend rect_blend_checker u_chk (.sys_clk_i, .reset_n_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pslverr_o, .vsync_i, .pix_valid_i,
  .dual_scaler_i, .layer_rgb_i, .gfx0_rgb_i, .gfx1_rgb_i, .out_rgb_o, .out_valid_o,
  .fade_alpha_o);
`default_nettype wire

// ### sim/tb.sv
// Purpose: register and pixel tests of the rectangle blend stage
// Assumes: zero-wait APB, one-cycle pixel latency
// Notes:   expected pixels use the block's divide-by-255 rounding
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic vsync_i = 0, pix_valid_i = 0, dual_scaler_i = 0, pready_o, pslverr_o, out_valid_o;
  logic [7:0] paddr_i = 0, layer_alpha_i = 0, gfx0_alpha_i = 0, gfx1_alpha_i = 0, fade_alpha_o;
  logic [31:0] pwdata_i = 0, prdata_o, q;
  logic [10:0] pos_x_i = 0, pos_y_i = 0;
  logic [23:0] layer_rgb_i = 0, under_rgb_i = 0, gfx0_rgb_i = 0, gfx1_rgb_i = 0, out_rgb_o;
  logic [23:0] t = 24'hFF8040, b = 24'h102030;
  logic [10:0] xs [6] = '{4, 8, 9, 3, 4, 4};
  logic [10:0] ys [6] = '{2, 4, 2, 2, 1, 5};
  logic [8:0]  steps [6] = '{9'h1F0, 9'h1F0, 9'h101, 9'h101, 9'h0FF, 9'h0FF};
  logic [7:0]  alphas [6] = '{8'hEF, 8'hDF, 8'h00, 8'h00, 8'hFF, 8'hFF};
  int fails = 0, checks_done = 0;
  rect_alpha_fade_blend u_dut (.sys_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .vsync_i, .pix_valid_i, .pos_x_i,
    .pos_y_i, .dual_scaler_i, .layer_rgb_i, .layer_alpha_i, .under_rgb_i, .gfx0_rgb_i,
    .gfx0_alpha_i, .gfx1_rgb_i, .gfx1_alpha_i, .out_rgb_o, .out_valid_o, .fade_alpha_o);
  always #12.5 sys_clk_i = ~sys_clk_i;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one transfer; holds everything until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, 1'b0, w, a, d};
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fails++;
      give_verdict();
    end
    else
    begin
      q = prdata_o;
      e = pslverr_o;
      {psel_i, penable_i} <= 2'b00;
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ex);
    logic e;
    apb(1'b0, a, 32'h0, e);
    chk("rdata", q, x);
    chk("pslverr", 32'(e), 32'(ex));
  endtask : rd
  task automatic px(input logic [10:0] x, input logic [10:0] y, input logic [7:0] pa);
    @(posedge sys_clk_i);
    {pos_x_i, pos_y_i, layer_rgb_i, gfx1_rgb_i, under_rgb_i, gfx0_rgb_i} <= {x, y, t, t, b, b};
    {layer_alpha_i, gfx0_alpha_i, gfx1_alpha_i, pix_valid_i} <= {pa, pa, pa, 1'b1};
    @(posedge sys_clk_i);
    pix_valid_i <= 1'b0;
    #1;
  endtask : px
  task automatic vs(input int k);
    repeat (k)
    begin
      @(posedge sys_clk_i);
      vsync_i <= 1'b1;
      @(posedge sys_clk_i);
      vsync_i <= 1'b0;
    end
    @(posedge sys_clk_i);
    #1;
  endtask : vs
  function automatic logic [7:0] rnd(input int v);
    return 8'(((v + 128) + ((v + 128) >> 8)) >> 8);
  endfunction : rnd
  function automatic logic [23:0] bl(input logic [23:0] tp, input logic [23:0] bt, input int a);
    for (int i = 0; i < 3; i++)
      bl[i*8 +: 8] = rnd(tp[i*8 +: 8] * a + bt[i*8 +: 8] * (255 - a));
  endfunction : bl
  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    rd(8'h10, 32'h0FF, 1'b0);
    rd(8'h0C, 32'h0, 1'b0);
    rd(8'h14, 32'h0, 1'b0);
    rd(8'h00, 32'h0, 1'b0);
    rd(8'h1C, 32'h0, 1'b1);
    wr(8'h18, 32'h0);
    rd(8'h18, 32'h0FF, 1'b0);
    wr(8'h04, 32'h0003_0002);
    wr(8'h08, 32'h0005_0004);
    wr(8'h10, 32'h0000_0080);
    wr(8'h00, 32'h1);
    rd(8'h08, 32'h0005_0004, 1'b0);
    // edges of the rectangle: first/last inside, one past each side
    for (int i = 0; i < 6; i++)
    begin
      px(xs[i], ys[i], 8'h40);
      chk("rect", 32'(out_rgb_o), 32'(i < 2 ? bl(t, b, 128) : t));
    end
    wr(8'h10, 32'h0000_0180);
    px(11'd4, 11'd2, 8'h80);
    chk("mul", 32'(out_rgb_o), 32'(bl(t, b, rnd(128 * 128))));
    wr(8'h00, 32'h0);
    px(11'd4, 11'd2, 8'h80);
    chk("off", 32'(out_rgb_o), 32'(t));
    rd(8'h04, 32'h0003_0002, 1'b0);
    wr(8'h00, 32'h1);
    wr(8'h10, 32'h0000_0080);
    // synthesizer target over all swap and dual-scaler settings
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h14, {30'h0, 1'b1, 1'(i >> 1)});
      dual_scaler_i <= 1'(i);
      px(11'd4, 11'd2, 8'h40);
      chk("synth", 32'(out_rgb_o), 32'(i == 3 ? bl(b, t, 128) : bl(t, b, 128)));
    end
    wr(8'h14, 32'h0);
    wr(8'h10, 32'h0000_00FF);
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h0C, {23'h0, steps[i]});
      vs(1);
      chk("fade", 32'(fade_alpha_o), 32'(alphas[i]));
    end
    wr(8'h0C, 32'h0000_0100);
    rd(8'h0C, 32'h0000_0101, 1'b0);
    wr(8'h0C, 32'h0002_01FF);
    wr(8'h10, 32'h0000_00FF);
    vs(2);
    chk("gap", 32'(fade_alpha_o), 32'h0FF);
    vs(1);
    chk("gap", 32'(fade_alpha_o), 32'h0FE);
    wr(8'h00, 32'h0);
    vs(3);
    chk("idle", 32'(fade_alpha_o), 32'h0FF);
    // a second reset must bring the horizontal rectangle, fade and alpha words back to their defaults
    @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    rd(8'h08, 32'h0, 1'b0);
    rd(8'h10, 32'h0FF, 1'b0);
    rd(8'h0C, 32'h0, 1'b0);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
